// file: dbgp_defs.vh
/*
 * Constants for the debug port and reset configuration block.
 * Assumes inclusion by its bare name from the design files.
 */
`ifndef DBGP_DEFS_VH
`define DBGP_DEFS_VH

// ----------------------------------------------------------------
// shift register and pin widths
// ----------------------------------------------------------------
`define DBGP_SHIFT_W 32
`define DBGP_CNT_W 5
`define DBGP_VF_W 3
`define DBGP_FLS_W 2
`define DBGP_WP_W 6
`define DBGP_WP_IBUS_LO 0
`define DBGP_WP_IBUS_HI 3
`define DBGP_WP_LBUS_LO 4
`define DBGP_WP_LBUS_HI 5

// ----------------------------------------------------------------
// reset timing and values
// ----------------------------------------------------------------
`define DBGP_RST_HOLD_NS 40
`define DBGP_CLK_NS 5
`define DBGP_RST_HOLD_CYC ((`DBGP_RST_HOLD_NS + `DBGP_CLK_NS - 1) / `DBGP_CLK_NS)
`define DBGP_RST_CNT_W 4
`define DBGP_SHIFT_RST 32'h00000000
`define DBGP_CNT_LAST 5'h1F

`endif

// file: dbgp_sync3.v
/*
 * Three-flop synchroniser with agreement filter.
 * Assumes an asynchronous pin on d_i; outside reset, output moves only when stages 2 and 3 agree.
 */
`timescale 1ns/1ps
`default_nettype none

module dbgp_sync3 (
  input wire core_clk_i,
  input wire rst_b_i,
  input wire d_i,
  input wire rst_val_i,
  output reg q_o
);

  reg s1_q;
  reg s2_q;
  reg s3_q;

  // first stage feeds only the second
  always @(posedge core_clk_i) begin
    s1_q <= d_i;
    s2_q <= s1_q;
    s3_q <= s2_q;
    if (!rst_b_i) begin
      q_o <= rst_val_i;
    end else if (s2_q == s3_q) begin
      q_o <= s3_q;
    end
  end

endmodule

`default_nettype wire

// file: dbgp_top.v
/*
 * Development port pins: serial shift link, reset configuration straps,
 * fetch visibility, flush count, watchpoints and the reset output.
 * Assumes the core supplies trace and watchpoint events on core_clk_i,
 * and the tool's serial clock is much slower than core_clk_i.
 */
// Overview of operation
// - Serial data is timed by the system clock out when self-clocked, else by the tool clock.
// - Each shift clock moves the serial input level into the shift register.
// - The serial output shows the level of each bit shifted out.
// - A high serial input during reset output selects data bus configuration.
// - A high serial clock during reset output enables debug mode, else normal operation.
// - The three-bit fetch visibility reports last fetch or queue flush count.
// - The two-bit flush count reports history flushes and carries the freeze indication when no flush is pending.
// - Watchpoint bits 0 to 3 flag instruction bus events and 4 to 5 load/store events.
// - Visibility, flush and watchpoint outputs may change every clock cycle.
// - The reset output stays asserted in reset and negates for normal operation.
`timescale 1ns/1ps
`default_nettype none
`include "dbgp_defs.vh"

module dbgp_top (
  input wire core_clk_i,
  input wire rst_b_i,
  input wire self_clocked_i,
  input wire debug_serial_in_i,
  input wire debug_serial_clock_i,
  input wire [`DBGP_SHIFT_W-1:0] load_word_i,
  input wire load_i,
  input wire [`DBGP_VF_W-1:0] fetch_visibility_i,
  input wire [`DBGP_FLS_W-1:0] flush_count_i,
  input wire freeze_i,
  input wire [`DBGP_WP_W-1:0] watch_event_i,
  output reg debug_serial_out_o,
  output reg system_clock_out_o,
  output reg reset_output_b_o,
  output reg cfg_from_data_bus_o,
  output reg debug_mode_en_o,
  output reg [`DBGP_SHIFT_W-1:0] shift_word_o,
  output reg word_valid_o,
  output reg [`DBGP_VF_W-1:0] fetch_visibility_o,
  output reg [`DBGP_FLS_W-1:0] flush_count_o,
  output reg [`DBGP_WP_W-1:0] watchpoint_o
);

  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  wire sdi_s;
  wire sck_s;

  dbgp_sync3 u_sync_sdi (
    .core_clk_i(core_clk_i),
    .rst_b_i(rst_b_i),
    .d_i(debug_serial_in_i),
    .rst_val_i(1'b0),
    .q_o(sdi_s)
  );

  dbgp_sync3 u_sync_sck (
    .core_clk_i(core_clk_i),
    .rst_b_i(rst_b_i),
    .d_i(debug_serial_clock_i),
    .rst_val_i(1'b0),
    .q_o(sck_s)
  );

  // ----------------------------------------------------------------
  // reset output and strap capture
  // ----------------------------------------------------------------
  reg [`DBGP_RST_CNT_W-1:0] rst_cnt_q;
  reg strap_sdi_q;
  reg strap_sck_q;

  // external reset drives all
  // held for a few cycles after release so synchronised straps settle
  always @(posedge core_clk_i) begin
    if (!rst_b_i) begin
      rst_cnt_q <= {`DBGP_RST_CNT_W{1'b0}};
      reset_output_b_o <= 1'b0;
    end else if (rst_cnt_q != `DBGP_RST_HOLD_CYC) begin
      rst_cnt_q <= rst_cnt_q + 1'b1;
      reset_output_b_o <= 1'b0;
    end else begin
      reset_output_b_o <= 1'b1;
    end
  end

  always @(posedge core_clk_i) begin
    if (!rst_b_i) begin
      strap_sdi_q <= 1'b0;
      strap_sck_q <= 1'b0;
      cfg_from_data_bus_o <= 1'b0;
      debug_mode_en_o <= 1'b0;
    end else if (!reset_output_b_o) begin
      strap_sdi_q <= sdi_s;
      strap_sck_q <= sck_s;
      // latch the level held over the previous cycle, so a pin moving at the edge is ignored
      if (rst_cnt_q == `DBGP_RST_HOLD_CYC) begin
        cfg_from_data_bus_o <= strap_sdi_q;
        debug_mode_en_o <= strap_sck_q;
      end
    end
  end

  // ----------------------------------------------------------------
  // system clock out divider, self-clocked shift timing
  // ----------------------------------------------------------------
  always @(posedge core_clk_i) begin
    if (!rst_b_i) begin
      system_clock_out_o <= 1'b0;
    end else begin
      system_clock_out_o <= ~system_clock_out_o;
    end
  end

  // ----------------------------------------------------------------
  // shift clock selection and edge detect
  // ----------------------------------------------------------------
  reg sck_prev_q;
  wire shift_tick;

  always @(posedge core_clk_i) begin
    if (!rst_b_i) begin
      sck_prev_q <= 1'b0;
    end else begin
      sck_prev_q <= sck_s;
    end
  end

  assign shift_tick = self_clocked_i ? ~system_clock_out_o : (sck_s & ~sck_prev_q);

  // ----------------------------------------------------------------
  // development port shift register
  // ----------------------------------------------------------------
  reg [`DBGP_SHIFT_W-1:0] shift_q;
  reg [`DBGP_CNT_W-1:0] bit_cnt_q;
  wire shifting;

  // only active once out of reset with debug mode on
  assign shifting = reset_output_b_o & debug_mode_en_o & shift_tick;

  always @(posedge core_clk_i) begin
    if (!rst_b_i) begin
      shift_q <= `DBGP_SHIFT_RST;
      bit_cnt_q <= {`DBGP_CNT_W{1'b0}};
      debug_serial_out_o <= 1'b0;
      shift_word_o <= `DBGP_SHIFT_RST;
      word_valid_o <= 1'b0;
    end else begin
      word_valid_o <= 1'b0;
      if (shifting) begin
        debug_serial_out_o <= shift_q[`DBGP_SHIFT_W-1];
        shift_q <= {shift_q[`DBGP_SHIFT_W-2:0], sdi_s};
        bit_cnt_q <= bit_cnt_q + 1'b1;
        if (bit_cnt_q == `DBGP_CNT_LAST) begin
          shift_word_o <= {shift_q[`DBGP_SHIFT_W-2:0], sdi_s};
          word_valid_o <= 1'b1;
        end
      end else if (load_i) begin
        // a parallel load in the same cycle as a shift is dropped
        shift_q <= load_word_i;
      end
    end
  end

  // ----------------------------------------------------------------
  // trace and watchpoint outputs, registered each cycle
  // ----------------------------------------------------------------
  // fetch visibility
  always @(posedge core_clk_i) begin
    if (!rst_b_i) begin
      fetch_visibility_o <= {`DBGP_VF_W{1'b0}};
      flush_count_o <= {`DBGP_FLS_W{1'b0}};
      watchpoint_o <= {`DBGP_WP_W{1'b0}};
    end else begin
      fetch_visibility_o <= fetch_visibility_i;
      // freeze shown as all ones when no flush is pending
      flush_count_o <= (freeze_i && flush_count_i == {`DBGP_FLS_W{1'b0}}) ?
                       {`DBGP_FLS_W{1'b1}} : flush_count_i;
      watchpoint_o[`DBGP_WP_IBUS_HI:`DBGP_WP_IBUS_LO] <=
        watch_event_i[`DBGP_WP_IBUS_HI:`DBGP_WP_IBUS_LO];
      watchpoint_o[`DBGP_WP_LBUS_HI:`DBGP_WP_LBUS_LO] <=
        watch_event_i[`DBGP_WP_LBUS_HI:`DBGP_WP_LBUS_LO];
    end
  end

endmodule

`default_nettype wire

// file: dbgp_top_properties.sv
/* port checker for dbgp_top
   assumes bind below and dbgp_defs.vh on the include path */
`timescale 1ns/1ps
`default_nettype none
`include "dbgp_defs.vh"
module dbgp_top_properties (
  input wire logic core_clk_i,
  input wire logic rst_b_i,
  input wire logic debug_serial_in_i,
  input wire logic debug_serial_clock_i,
  input wire logic [`DBGP_VF_W-1:0] fetch_visibility_i,
  input wire logic [`DBGP_FLS_W-1:0] flush_count_i,
  input wire logic freeze_i,
  input wire logic [`DBGP_WP_W-1:0] watch_event_i,
  input wire logic debug_serial_out_o,
  input wire logic reset_output_b_o,
  input wire logic cfg_from_data_bus_o,
  input wire logic debug_mode_en_o,
  input wire logic word_valid_o,
  input wire logic [`DBGP_VF_W-1:0] fetch_visibility_o,
  input wire logic [`DBGP_FLS_W-1:0] flush_count_o,
  input wire logic [`DBGP_WP_W-1:0] watchpoint_o
);
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (!rst_b_i);
  a_vf_copy: assert property ($past(rst_b_i) |-> fetch_visibility_o == $past(fetch_visibility_i))
    else $error("fetch visibility not copied");
  a_flush_freeze: assert property ($past(rst_b_i) |-> flush_count_o ==
    (($past(freeze_i) && $past(flush_count_i) == 2'h0) ? 2'h3 : $past(flush_count_i)))
    else $error("flush count wrong");
  a_wp_copy: assert property ($past(rst_b_i) |-> watchpoint_o == $past(watch_event_i))
    else $error("watchpoint not copied");
  a_rstout_hold: assert property ($rose(rst_b_i) |-> !reset_output_b_o [*8])
    else $error("reset output released early");
  a_rstout_rise: assert property ($rose(rst_b_i) |-> ##[1:20] reset_output_b_o)
    else $error("reset output never released");
  a_strap_hold: assert property ($past(reset_output_b_o) |->
    $stable(cfg_from_data_bus_o) && $stable(debug_mode_en_o)) else $error("straps moved");
  a_strap_take: assert property ($rose(reset_output_b_o) |->
    cfg_from_data_bus_o == debug_serial_in_i && debug_mode_en_o == debug_serial_clock_i)
    else $error("straps not latched");
  a_shift_off: assert property (!debug_mode_en_o |=> !word_valid_o && $stable(debug_serial_out_o))
    else $error("shift while debug off");
  c_word: cover property (word_valid_o);
  c_debug: cover property ($rose(reset_output_b_o) && debug_mode_en_o);
  c_freeze: cover property (flush_count_o == 2'h3);
endmodule
bind dbgp_top dbgp_top_properties u_chk (.*);
`default_nettype wire

// file: dbgp_tool_model.sv
/* serial debug tool model
   assumes the bench calls its tasks; clock stands low between frames */
`timescale 1ns/1ps
`default_nettype none
module dbgp_tool (
  input wire logic so_i,
  output logic sck_o,
  output logic sdi_o
);
  initial begin
    sck_o = 1'b0;
    sdi_o = 1'b0;
  end
  task strap(input logic d, input logic c);
    sdi_o = d;
    sck_o = c;
  endtask
  task frame(input logic [31:0] d, output logic [31:0] q);
    for (int i = 31; i >= 0; i--) begin
      sdi_o = d[i];
      #40 sck_o = 1'b1;
      #35 q = {q[30:0], so_i};
      #5 sck_o = 1'b0;
    end
    // drive the inverse of the last bit after the frame
    sdi_o = ~sdi_o;
  endtask
endmodule
`default_nettype wire

// file: dbgp_top_tb_top.sv
/* bench for dbgp_top
   assumes the tool model and the bound checker are compiled alongside */
`timescale 1ns/1ps
`default_nettype none
module dbgp_top_tb_top;
  logic core_clk_i = 1'b0;
  logic rst_b_i = 1'b0;
  logic self_clocked_i = 1'b0;
  logic load_i = 1'b0;
  logic [31:0] load_word_i = 32'h0;
  logic [11:0] tr = 12'h0;
  logic [15:0] seed = 16'h811D;
  logic [31:0] got, w, r, sw;
  wire sdi, sck, so, rso, cfg, dbg, wv, sco;
  logic sc0;
  integer failures = 0, cmp_count = 0, vcount = 0, v;
  function [15:0] lfsr(input [15:0] x);
    lfsr = {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
  endfunction
  dbgp_tool tool (.so_i(so), .sck_o(sck), .sdi_o(sdi));
  dbgp_top DUT (.core_clk_i(core_clk_i), .rst_b_i(rst_b_i), .self_clocked_i(self_clocked_i),
    .debug_serial_in_i(sdi), .debug_serial_clock_i(sck), .load_word_i(load_word_i),
    .load_i(load_i), .fetch_visibility_i(tr[2:0]), .flush_count_i(tr[4:3]),
    .freeze_i(tr[5]), .watch_event_i(tr[11:6]), .debug_serial_out_o(so),
    .system_clock_out_o(sco), .reset_output_b_o(rso), .cfg_from_data_bus_o(cfg),
    .debug_mode_en_o(dbg), .shift_word_o(sw), .word_valid_o(wv), .fetch_visibility_o(),
    .flush_count_o(), .watchpoint_o());
  always #2.5 core_clk_i = ~core_clk_i;
  always @(posedge core_clk_i) begin
    #1;
    seed = lfsr(seed);
    tr = seed[11:0];
    vcount = vcount + wv;
  end
  task chk(input string n, input logic [31:0] s, input logic [31:0] e);
    cmp_count++;
    if (s !== e) begin
      failures++;
      $display("[ERR] %s expected %h seen %h", n, e, s);
    end
  endtask
  task cyc(input integer n);
    repeat (n) @(posedge core_clk_i);
    #1;
  endtask
  task test_done;
    $display("checks %0d mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  task boot(input logic d, input logic c);
    integer i;
    tool.strap(d, c);
    // bench reset goes to the DUT only, the tool model has no reset
    rst_b_i = 1'b0;
    cyc(16);
    rst_b_i = 1'b1;
    for (i = 0; i < 40 && rso !== 1'b1; i++) cyc(1);
    if (i == 40) begin
      failures++;
      test_done;
    end
    cyc(4);
    chk("cfg", cfg, d);
    chk("dbg", dbg, c);
    sc0 = sco;
    cyc(1);
    chk("system_clock_out", {31'h0, sco}, {31'h0, ~sc0});
    tool.strap(~d, 1'b0);
    $display("boot done");
  endtask
  initial begin
    boot(1'b1, 1'b1);
    w = {seed, lfsr(seed)};
    r = {lfsr(seed), ~seed};
    load_word_i = w;
    load_i = 1'b1;
    cyc(1);
    load_i = 1'b0;
    tool.frame(r, got);
    chk("out", got, w);
    chk("word", sw, r);
    chk("valid", vcount, 1);
    // self-clocked word of ones
    tool.strap(1'b1, 1'b0);
    cyc(8);
    self_clocked_i = 1'b1;
    for (v = 0; v < 200 && vcount < 2; v++) cyc(1);
    if (vcount < 2) begin
      failures++;
      test_done;
    end
    chk("self", sw, 32'hFFFFFFFF);
    self_clocked_i = 1'b0;
    $display("frames done");
    boot(1'b0, 1'b0);
    v = vcount;
    tool.frame(r, got);
    chk("refuse", vcount, v);
    test_done;
  end
endmodule
`default_nettype wire
